// ===== inc/cdt_pkg.sv
// Purpose: shared constants and types of the countdown and periodic tick timer
// Assumes: 8-bit register port, oscillator edges arrive on a 32.768 kHz pin
// Notes:   offsets are byte addresses of the register port
package cdt_pkg;

    // register offsets
    localparam logic [7:0] ADDR_EVENT_FLAG_STATUS   = 8'h01;
    localparam logic [7:0] ADDR_TIMER_CLOCK_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_COUNTDOWN_VALUE     = 8'h0F;

    // event_flag_status field positions
    localparam int STS_MINUTE_EN   = 7;
    localparam int STS_SECOND_EN   = 6;
    localparam int STS_TICK_FLAG   = 5;
    localparam int STS_PULSE_SEL   = 4;
    localparam int STS_ALARM_FLAG  = 3;
    localparam int STS_CD_FLAG     = 2;
    localparam int STS_ALARM_IRQEN = 1;
    localparam int STS_CD_IRQEN    = 0;

    // timer_clock_control field positions
    localparam int TCC_COF_LSB = 4;
    localparam int TCC_RUN     = 3;
    localparam int TCC_SRC_LSB = 0;

    // values after reset
    localparam logic [7:0] RST_STATUS    = 8'h00;
    localparam logic [2:0] RST_COF       = 3'h0;
    localparam logic [1:0] RST_SRC_SEL   = 2'h3;
    localparam logic [7:0] RST_COUNTDOWN = 8'h00;

    // divider ratios, counted in oscillator or tick events
    localparam int DIV_OSC_TO_4K   = 8;
    localparam int DIV_4K_TO_64    = 64;
    localparam int DIV_OSC_TO_1HZ  = 32768;
    localparam int DIV_1HZ_TO_MIN  = 60;

    typedef enum logic [1:0] {
        CDT_SRC_4K  = 2'h0,
        CDT_SRC_64  = 2'h1,
        CDT_SRC_1HZ = 2'h2,
        CDT_SRC_MIN = 2'h3
    } cdt_src_t;

    typedef enum logic [2:0] {
        CDT_CD_IDLE = 3'b001,
        CDT_CD_ARM  = 3'b010,
        CDT_CD_RUN  = 3'b100
    } cdt_cd_state_t;

endpackage

// ===== inc/cdt_div_if.sv
// Purpose: step and wrap signals between the timer and one of its dividers
// Assumes: all signals on the timer clock
// Notes:   fast and slow apply a frequency correction of one step
`timescale 1ns/10ps
interface cdt_div_if;
    logic step;
    logic fast;
    logic slow;
    logic wrap;
    modport parent (output step, output fast, output slow, input wrap);
    modport div    (input step, input fast, input slow, output wrap);
endinterface

// ===== hw/cdt_div.sv
// Purpose: modulo event divider with one-step correction
// Assumes: step is a one-cycle pulse on clk_i
// Notes:   wrap is combinational, high in the step cycle that closes a period
`timescale 1ns/10ps
module cdt_div #(
    parameter int MOD = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    cdt_div_if.div    port_if
);
    localparam int             W    = (MOD > 2) ? $clog2(MOD) : 1;
    localparam logic [W-1:0]   LAST = W'(MOD - 1);
    localparam logic [W-1:0]   PRE  = W'(MOD - 2);

    logic [W-1:0] cnt_q;
    logic         adv;
    logic         hit;

    always_comb begin
        // slow holds the count for one step, fast advances it by two
        adv = port_if.step & ~port_if.slow;
        hit = adv & ((cnt_q == LAST) | (port_if.fast & (cnt_q == PRE)));
    end

    assign port_if.wrap = hit;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (hit) begin
            cnt_q <= '0;
        end else if (adv) begin
            cnt_q <= cnt_q + (port_if.fast ? W'(2) : W'(1));
        end
    end
endmodule

// ===== hw/cdt_timer.sv
// Purpose: periodic second/minute tick and 8-bit auto-reload countdown timer
// Assumes: register port on mclk_i, oscillator pin asynchronous to mclk_i
// Notes:   oscillator rising edges drive every timebase of the block
`timescale 1ns/10ps
module cdt_timer
    import cdt_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       osc_32k_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       alarm_match_i,
    input  wire logic       corr_fast_i,
    input  wire logic       corr_slow_i,
    output logic      [7:0] reg_rdata_o,
    output logic            int_n_o,
    output logic            sec_tick_o,
    output logic            min_tick_o
);

    ////////////////////////////////////////////////////////////////////////////
    // oscillator pin synchroniser

    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_rise;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_32k_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_rise = osc_s2_q & ~osc_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // timebase dividers

    logic fast_pend_q;
    logic slow_pend_q;

    // correction requests wait for the next oscillator edge; slow wins when both are pending
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_pend_q <= 1'b0;
            slow_pend_q <= 1'b0;
        end else begin
            fast_pend_q <= corr_fast_i | (fast_pend_q & ~osc_rise);
            slow_pend_q <= corr_slow_i | (slow_pend_q & ~osc_rise);
        end
    end

    cdt_div_if if_4k  ();
    cdt_div_if if_64  ();
    cdt_div_if if_1s  ();
    cdt_div_if if_min ();

    assign if_4k.step  = osc_rise;
    assign if_4k.fast  = 1'b0;
    assign if_4k.slow  = 1'b0;
    assign if_64.step  = if_4k.wrap;
    assign if_64.fast  = 1'b0;
    assign if_64.slow  = 1'b0;
    assign if_1s.step  = osc_rise;
    assign if_1s.fast  = fast_pend_q;
    assign if_1s.slow  = slow_pend_q;
    assign if_min.step = if_1s.wrap;
    assign if_min.fast = 1'b0;
    assign if_min.slow = 1'b0;

    cdt_div #(.MOD(DIV_OSC_TO_4K)) u_div_4k (
        .clk_i   (mclk_i),
        .rst_i   (rst_i),
        .port_if (if_4k)
    );

    cdt_div #(.MOD(DIV_4K_TO_64)) u_div_64 (
        .clk_i   (mclk_i),
        .rst_i   (rst_i),
        .port_if (if_64)
    );

    cdt_div #(.MOD(DIV_OSC_TO_1HZ)) u_div_1s (
        .clk_i   (mclk_i),
        .rst_i   (rst_i),
        .port_if (if_1s)
    );

    cdt_div #(.MOD(DIV_1HZ_TO_MIN)) u_div_min (
        .clk_i   (mclk_i),
        .rst_i   (rst_i),
        .port_if (if_min)
    );

    logic tick_4k;
    logic tick_64;
    logic tick_1s;
    logic tick_min;

    assign tick_4k  = if_4k.wrap;
    assign tick_64  = if_64.wrap;
    assign tick_1s  = if_1s.wrap;
    assign tick_min = if_min.wrap;

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    logic       wr_sts;
    logic       wr_tcc;
    logic       wr_cnt;
    logic       minute_tick_enable_q;
    logic       second_tick_enable_q;
    logic       irq_pulse_select_q;
    logic       alarm_irq_enable_q;
    logic       countdown_irq_enable_q;
    logic       countdown_run_q;
    logic [1:0] source_clock_select_q;
    logic [2:0] clkout_sel_q;
    logic [7:0] reload_q;

    assign wr_sts = reg_wr_i & (reg_addr_i == ADDR_EVENT_FLAG_STATUS);
    assign wr_tcc = reg_wr_i & (reg_addr_i == ADDR_TIMER_CLOCK_CONTROL);
    assign wr_cnt = reg_wr_i & (reg_addr_i == ADDR_COUNTDOWN_VALUE);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            minute_tick_enable_q   <= RST_STATUS[STS_MINUTE_EN];
            second_tick_enable_q   <= RST_STATUS[STS_SECOND_EN];
            irq_pulse_select_q     <= RST_STATUS[STS_PULSE_SEL];
            alarm_irq_enable_q     <= RST_STATUS[STS_ALARM_IRQEN];
            countdown_irq_enable_q <= RST_STATUS[STS_CD_IRQEN];
        end else if (wr_sts) begin
            minute_tick_enable_q   <= reg_wdata_i[STS_MINUTE_EN];
            second_tick_enable_q   <= reg_wdata_i[STS_SECOND_EN];
            irq_pulse_select_q     <= reg_wdata_i[STS_PULSE_SEL];
            alarm_irq_enable_q     <= reg_wdata_i[STS_ALARM_IRQEN];
            countdown_irq_enable_q <= reg_wdata_i[STS_CD_IRQEN];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            countdown_run_q       <= 1'b0;
            source_clock_select_q <= RST_SRC_SEL;
            clkout_sel_q          <= RST_COF;
        end else if (wr_tcc) begin
            countdown_run_q       <= reg_wdata_i[TCC_RUN];
            source_clock_select_q <= reg_wdata_i[TCC_SRC_LSB +: 2];
            clkout_sel_q          <= reg_wdata_i[TCC_COF_LSB +: 3];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reload_q <= RST_COUNTDOWN;
        end else if (wr_cnt) begin
            reload_q <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control into the timer domain

    logic [7:0] ctl_raw;
    logic [7:0] ctl_s1_q;
    logic [7:0] ctl_s2_q;
    logic       min_en;
    logic       sec_en;
    logic       pulse_sel;
    logic       aie;
    logic       countdown_irq_enable;
    logic       run;
    cdt_src_t   src;

    assign ctl_raw = {minute_tick_enable_q, second_tick_enable_q, irq_pulse_select_q,
                      alarm_irq_enable_q, countdown_irq_enable_q, countdown_run_q,
                      source_clock_select_q};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_s1_q <= {RST_STATUS[STS_MINUTE_EN], RST_STATUS[STS_SECOND_EN],
                         RST_STATUS[STS_PULSE_SEL], RST_STATUS[STS_ALARM_IRQEN],
                         RST_STATUS[STS_CD_IRQEN], 1'b0, RST_SRC_SEL};
            ctl_s2_q <= {RST_STATUS[STS_MINUTE_EN], RST_STATUS[STS_SECOND_EN],
                         RST_STATUS[STS_PULSE_SEL], RST_STATUS[STS_ALARM_IRQEN],
                         RST_STATUS[STS_CD_IRQEN], 1'b0, RST_SRC_SEL};
        end else begin
            ctl_s1_q <= ctl_raw;
            ctl_s2_q <= ctl_s1_q;
        end
    end

    assign min_en    = ctl_s2_q[7];
    assign sec_en    = ctl_s2_q[6];
    assign pulse_sel = ctl_s2_q[5];
    assign aie       = ctl_s2_q[4];
    assign countdown_irq_enable       = ctl_s2_q[3];
    assign run       = ctl_s2_q[2];
    assign src       = cdt_src_t'(ctl_s2_q[1:0]);

    ////////////////////////////////////////////////////////////////////////////
    // countdown

    cdt_cd_state_t cd_state_q;
    logic [7:0]    cnt_q;
    logic          src_tick;
    logic          slow_src;
    logic          load_evt;
    logic          cd_evt;

    always_comb begin
        unique case (src)
            CDT_SRC_4K:  src_tick = tick_4k;
            CDT_SRC_64:  src_tick = tick_64;
            CDT_SRC_1HZ: src_tick = tick_1s;
            CDT_SRC_MIN: src_tick = tick_min;
        endcase
    end

    assign slow_src = (src == CDT_SRC_1HZ) | (src == CDT_SRC_MIN);
    assign load_evt = slow_src ? tick_64 : src_tick;
    assign cd_evt   = (cd_state_q == CDT_CD_RUN) & src_tick & (cnt_q == 8'h01) & ~wr_cnt;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cd_state_q <= CDT_CD_IDLE;
        end else if (!run) begin
            cd_state_q <= CDT_CD_IDLE;
        end else begin
            unique case (cd_state_q)
                CDT_CD_IDLE: cd_state_q <= CDT_CD_ARM;
                CDT_CD_ARM:  if (load_evt) begin
                    cd_state_q <= CDT_CD_RUN;
                end
                CDT_CD_RUN:  cd_state_q <= CDT_CD_RUN;
                default:     cd_state_q <= CDT_CD_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= RST_COUNTDOWN;
        end else if (wr_cnt) begin
            cnt_q <= reg_wdata_i;
        end else if (cd_state_q == CDT_CD_ARM && run && load_evt) begin
            cnt_q <= reload_q;
        end else if (cd_evt) begin
            cnt_q <= reload_q;
        end else if (cd_state_q == CDT_CD_RUN && src_tick && cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags

    logic per_evt;
    logic clr_msf;
    logic clr_af;
    logic clr_tf;
    logic msf_q;
    logic af_q;
    logic tf_q;

    assign per_evt = sec_en ? tick_1s : (min_en & tick_min);

    assign clr_msf = wr_sts & ~reg_wdata_i[STS_TICK_FLAG];
    assign clr_af  = wr_sts & ~reg_wdata_i[STS_ALARM_FLAG];
    assign clr_tf  = wr_sts & ~reg_wdata_i[STS_CD_FLAG];

    // a new event in the clearing cycle keeps its flag
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            msf_q <= RST_STATUS[STS_TICK_FLAG];
            af_q  <= RST_STATUS[STS_ALARM_FLAG];
            tf_q  <= RST_STATUS[STS_CD_FLAG];
        end else begin
            msf_q <= per_evt | (msf_q & ~clr_msf);
            af_q  <= alarm_match_i | (af_q & ~clr_af);
            tf_q  <= cd_evt | (tf_q & ~clr_tf);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pulses and output

    logic per_pulse_q;
    logic cd_pulse_q;
    logic cd_pulse_end;
    logic irq;

    // tick pulse until next 64 Hz
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            per_pulse_q <= 1'b0;
        end else if (per_evt) begin
            per_pulse_q <= 1'b1;
        end else if (tick_64 || clr_msf) begin
            per_pulse_q <= 1'b0;
        end
    end

    assign cd_pulse_end = (slow_src ? tick_64 : src_tick) | clr_tf;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cd_pulse_q <= 1'b0;
        end else if (cd_evt) begin
            cd_pulse_q <= 1'b1;
        end else if (cd_pulse_end) begin
            cd_pulse_q <= 1'b0;
        end
    end

    assign irq = ((min_en | sec_en) & (pulse_sel ? per_pulse_q : msf_q))
               | (countdown_irq_enable & (pulse_sel ? cd_pulse_q : tf_q))
               | (aie & af_q);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            int_n_o    <= 1'b1;
            sec_tick_o <= 1'b0;
            min_tick_o <= 1'b0;
        end else begin
            int_n_o    <= ~irq;
            sec_tick_o <= tick_1s;
            min_tick_o <= tick_min;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_EVENT_FLAG_STATUS:   reg_rdata_o <= {minute_tick_enable_q,
                    second_tick_enable_q, msf_q, irq_pulse_select_q, af_q, tf_q,
                    alarm_irq_enable_q, countdown_irq_enable_q};
                ADDR_TIMER_CLOCK_CONTROL: reg_rdata_o <= {1'b0, clkout_sel_q,
                    countdown_run_q, 1'b0, source_clock_select_q};
                ADDR_COUNTDOWN_VALUE:     reg_rdata_o <= cnt_q;
                default:                  reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

// ===== verif/cdt_timer_props.sv
// Purpose: port checks of cdt_timer
// Assumes: single clock mclk_i
// Notes:   shadow flops follow host writes
`timescale 1ns/10ps
module cdt_timer_props
    import cdt_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       osc_32k_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       alarm_match_i,
    input wire logic       corr_fast_i,
    input wire logic       corr_slow_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       int_n_o,
    input wire logic       sec_tick_o,
    input wire logic       min_tick_o
);
    ////////////////////////////////////////
    logic [7:0] reload_q;
    logic       tick_en_q;
    logic       irq_en_q;
    wire        st_wr = reg_wr_i && reg_addr_i == ADDR_EVENT_FLAG_STATUS;
    wire        st_rd = reg_rd_i && reg_addr_i == ADDR_EVENT_FLAG_STATUS;
    wire        cd_rd = reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_COUNTDOWN_VALUE;
    wire        mapped = reg_addr_i inside {ADDR_EVENT_FLAG_STATUS, ADDR_TIMER_CLOCK_CONTROL,
                                            ADDR_COUNTDOWN_VALUE};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reload_q <= RST_COUNTDOWN;
        end else if (reg_wr_i && reg_addr_i == ADDR_COUNTDOWN_VALUE) begin
            reload_q <= reg_wdata_i;
        end
    end

    // enables ever written since reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_en_q <= 1'b0;
            irq_en_q  <= 1'b0;
        end else if (st_wr) begin
            tick_en_q <= tick_en_q | reg_wdata_i[STS_MINUTE_EN] | reg_wdata_i[STS_SECOND_EN];
            irq_en_q  <= irq_en_q | reg_wdata_i[STS_ALARM_IRQEN] | reg_wdata_i[STS_CD_IRQEN];
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ctrl_unused_a: assert property (
        reg_rd_i && reg_addr_i == ADDR_TIMER_CLOCK_CONTROL |=> (reg_rdata_o & 8'h84) == 8'h00)
        else $error("unused control bits read set");
    live_count_a: assert property (
        cd_rd |=> ((reload_q == 8'h00) ? (reg_rdata_o == 8'h00)
                   : (reg_rdata_o != 8'h00 && reg_rdata_o <= reload_q)))
        else $error("countdown read outside one to reload");
    tick_flag_quiet_a: assert property (
        st_rd && !tick_en_q |=> !reg_rdata_o[STS_TICK_FLAG])
        else $error("tick flag set with both enables clear");
    int_idle_a: assert property (!tick_en_q && !irq_en_q |-> int_n_o)
        else $error("interrupt without any enable");
    flag_clear_a: assert property (
        (st_wr && !reg_wdata_i[STS_ALARM_FLAG] && !alarm_match_i) ##1 !alarm_match_i
        ##1 (st_rd && !alarm_match_i) |=> !reg_rdata_o[STS_ALARM_FLAG])
        else $error("flag survived a zero write");
    ctrl_store_a: assert property (
        st_wr ##2 st_rd |=> (reg_rdata_o & 8'hD3) == ($past(reg_wdata_i, 3) & 8'hD3))
        else $error("status control bits not stored");
    int_release_a: assert property (
        (st_wr && reg_wdata_i == 8'h00) ##1 (!st_wr)[*5] |-> int_n_o)
        else $error("interrupt held after all cleared");
endmodule

bind cdt_timer cdt_timer_props i_cdt_timer_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .osc_32k_i(osc_32k_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .alarm_match_i(alarm_match_i), .corr_fast_i(corr_fast_i), .corr_slow_i(corr_slow_i),
    .reg_rdata_o(reg_rdata_o), .int_n_o(int_n_o), .sec_tick_o(sec_tick_o),
    .min_tick_o(min_tick_o)
);

// ===== verif/cdt_host_model.sv
// Purpose: host side of the register port
// Assumes: strobes change 2 ns after mclk_i rises
// Notes:   idle address and data show inverted last value
`timescale 1ns/10ps
module cdt_host_model
    import cdt_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #2;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge mclk_i);
        #2;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        #2;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge mclk_i);
        #2;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask

    task automatic rd_stable(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] p;
        rd(a, p);
        rd(a, d);
        for (int k = 0; k < 3 && d !== p; k++) begin
            p = d;
            rd(a, d);
        end
    endtask

    task automatic clear_cd();
        logic [7:0] s;
        rd(ADDR_EVENT_FLAG_STATUS, s);
        wr(ADDR_EVENT_FLAG_STATUS, (s | 8'h28) & 8'hFB);
    endtask

    task automatic park();
        wr(ADDR_TIMER_CLOCK_CONTROL, 8'h03);
    endtask
endmodule

// ===== verif/tb_cdt_timer.sv
// Purpose: self-checking bench of cdt_timer
// Assumes: oscillator pin at 8 clock cycles a period
// Notes:   seconds and minutes too slow to reach here
`timescale 1ns/10ps
module tb_cdt_timer
    import cdt_pkg::*;
;
    localparam int OSC_CYC = 8;
    logic        mclk = 1'b0;
    logic        rst_i = 1'b1;
    logic        osc = 1'b0;
    logic        alarm = 1'b0;
    logic        wr, rd, int_n, sec_t, min_t;
    logic  [7:0] tck_n = 8'h00;
    logic  [7:0] addr, wdata, rdata, v, c;
    logic [31:0] seed = 32'hBC36363A;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n, m, t1, t2;

    always #12.5 mclk = ~mclk;
    always #100 osc = ~osc;
    always @(posedge mclk) cyc <= cyc + 1;
    // second and minute pulses seen on the pins
    always @(posedge mclk) begin
        if (sec_t || min_t) tck_n <= tck_n + 8'h01;
    end

    cdt_timer i_cdt_timer (
        .mclk_i(mclk), .rst_i(rst_i), .osc_32k_i(osc), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .alarm_match_i(alarm), .corr_fast_i(1'b0),
        .corr_slow_i(1'b0), .reg_rdata_o(rdata), .int_n_o(int_n), .sec_tick_o(sec_t),
        .min_tick_o(min_t)
    );
    cdt_host_model i_cdt_host_model (
        .mclk_i(mclk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata)
    );

    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int exp_period(input int src, input int cnt);
        return DIV_OSC_TO_4K * OSC_CYC * cnt * (src == 1 ? DIV_4K_TO_64 : 1);
    endfunction
    task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cyc(input string nm, input int e, input int g);
        tests_run++;
        if (g < e - 1 || g > e + 1) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_cdt_host_model.wr(a, d);
    endtask
    task automatic r(input logic [7:0] a, output logic [7:0] d);
        i_cdt_host_model.rd(a, d);
    endtask
    task automatic wait_lvl(input logic lv, input int max);
        int k;
        k = 0;
        while (int_n !== lv && k < max) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (int_n !== lv) chk_val("int_n", {7'h0, lv}, {7'h0, int_n});
    endtask
    task automatic quiet(input int k);
        logic lo;
        lo = 1'b0;
        repeat (k) begin
            @(posedge mclk);
            #1;
            lo = lo | (int_n !== 1'b1);
        end
        chk_val("quiet", 8'h00, {7'h0, lo});
    endtask
    task automatic next_fall(input int max, output int t);
        i_cdt_host_model.clear_cd();
        wait_lvl(1'b1, 8);
        wait_lvl(1'b0, max);
        t = cyc;
    endtask
    task automatic fire();
        @(posedge mclk);
        #2;
        alarm = 1'b1;
        @(posedge mclk);
        #2;
        alarm = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        #(25 * 80000);
        err_count++;
        $display("MISMATCH watchdog expected done seen hang");
        test_done();
    end

    initial begin
        repeat (6) @(posedge mclk);
        #2;
        rst_i = 1'b0;
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("status", RST_STATUS, v);
        r(ADDR_TIMER_CLOCK_CONTROL, v);
        chk_val("ctrl", {1'b0, RST_COF, 2'h0, RST_SRC_SEL}, v);
        r(ADDR_COUNTDOWN_VALUE, v);
        chk_val("count", RST_COUNTDOWN, v);
        r(8'h3C, v);
        chk_val("unmapped", 8'h00, v);
        for (int s = 0; s < 4; s++) begin
            seed = xs(seed);
            c = {seed[7:4], 1'b0, seed[2], s[1:0]};
            w(ADDR_TIMER_CLOCK_CONTROL, c);
            r(ADDR_TIMER_CLOCK_CONTROL, v);
            chk_val("ctrl", c & 8'h7B, v);
        end
        seed = xs(seed);
        n = 2 + int'(seed[1:0]);
        w(ADDR_COUNTDOWN_VALUE, 8'(n));
        w(ADDR_EVENT_FLAG_STATUS, 8'h01);
        w(ADDR_TIMER_CLOCK_CONTROL, 8'h08);
        wait_lvl(1'b0, 2000);
        t1 = cyc;
        repeat (96) @(posedge mclk);
        i_cdt_host_model.rd_stable(ADDR_COUNTDOWN_VALUE, v);
        chk_val("live", 8'(n - 1), v);
        repeat (n * 64) @(posedge mclk);
        #1;
        chk_val("held", 8'h00, {7'h0, int_n});
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("flags", 8'h05, v);
        next_fall(n * 64, t2);
        chk_cyc("period", exp_period(0, 2 * n), t2 - t1);
        seed = xs(seed);
        m = 2 + int'(seed[3:2]);
        w(ADDR_COUNTDOWN_VALUE, 8'(m));
        next_fall(m * 64 + 8, t1);
        next_fall(m * 64 + 8, t2);
        chk_cyc("reload", exp_period(0, m), t2 - t1);
        w(ADDR_EVENT_FLAG_STATUS, 8'h11);
        wait_lvl(1'b1, 8);
        wait_lvl(1'b0, m * 64 + 8);
        t1 = cyc;
        wait_lvl(1'b1, 72);
        wait_lvl(1'b0, m * 64);
        t2 = cyc;
        chk_cyc("pulse", exp_period(0, m), t2 - t1);
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("sticky", 8'h15, v);
        w(ADDR_EVENT_FLAG_STATUS, 8'h14);
        repeat (4) @(posedge mclk);
        quiet(m * 64 + 8);
        w(ADDR_COUNTDOWN_VALUE, 8'h00);
        w(ADDR_EVENT_FLAG_STATUS, 8'h01);
        repeat (4) @(posedge mclk);
        quiet(m * 128);
        r(ADDR_COUNTDOWN_VALUE, v);
        chk_val("stopped", 8'h00, v);
        w(ADDR_TIMER_CLOCK_CONTROL, 8'h01);
        w(ADDR_COUNTDOWN_VALUE, 8'h02);
        w(ADDR_EVENT_FLAG_STATUS, 8'h11);
        w(ADDR_TIMER_CLOCK_CONTROL, 8'h09);
        wait_lvl(1'b0, 13000);
        t1 = cyc;
        wait_lvl(1'b1, 4200);
        wait_lvl(1'b0, 4200);
        t2 = cyc;
        chk_cyc("slow", exp_period(1, 2), t2 - t1);
        i_cdt_host_model.park();
        seed = xs(seed);
        c = seed[7:0] & 8'hD3;
        w(ADDR_EVENT_FLAG_STATUS, c);
        fire();
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("alarm", c | 8'h08, v);
        w(ADDR_EVENT_FLAG_STATUS, c | 8'h2C);
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("keep", c | 8'h08, v);
        w(ADDR_EVENT_FLAG_STATUS, c | 8'h24);
        r(ADDR_EVENT_FLAG_STATUS, v);
        chk_val("clear", c, v);
        w(ADDR_EVENT_FLAG_STATUS, 8'h02);
        fire();
        wait_lvl(1'b0, 8);
        w(ADDR_EVENT_FLAG_STATUS, 8'h00);
        wait_lvl(1'b1, 8);
        repeat (8) @(posedge mclk);
        chk_val("ticks", 8'(cyc / (DIV_OSC_TO_1HZ * OSC_CYC)), tck_n);
        test_done();
    end
endmodule
